// ---- logic/la_capture_ctrl.sv ----
// Logic analyzer arm, capture and status controller with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "la_map.svh"
module la_capture_ctrl (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Probed design, same clock
  input wire logic [`LA_PROBE_W-1:0] I_PROBE,
  input wire logic I_TRIGGER,
  input wire logic I_CAPTURE_COND,
  input wire logic [3:0] I_TSM_FLAGS,
  input wire logic [3:0] I_TSM_STATE,
  // Run state
  output la_pkg::run_state_t O_RUN_STATE
);
  import la_pkg::*;

  localparam int CW = `LA_CNT_W;

  run_state_t state_r, state_nxt; // Engine state
  bus_req_t req_r, req_nxt; // Latched address phase
  cap_cfg_t cfg_r, cfg_nxt; // Capture configuration
  logic [7:0] tpos_r, tpos_nxt; // Trigger position
  logic [7:0] rdaddr_r, rdaddr_nxt; // Upload read pointer
  logic [31:0] hrdata_r, hrdata_nxt; // Read data
  logic imm_r, imm_nxt; // Immediate trigger armed
  logic [CW-1:0] avail_r, avail_nxt; // Windows offered for upload
  logic [8:0] mem [0:255]; // Sample buffer, mark in bit 8
  logic [CW-1:0] win_cnt, samp_cnt, tot_cnt; // Status counts
  logic win_clr, win_inc, samp_clr, samp_inc, tot_clr; // Counter controls
  logic mem_we, mem_mark, win_done; // Store strobes
  logic [3:0] winl, wlog; // Clamped log2 of windows and depth
  logic [CW-1:0] wdepth, nwin, pos, last; // Window geometry
  logic [CW-1:0] waddr; // Buffer write address
  logic store_en, trig; // Sample and trigger qualifiers
  logic wr_dp, cmd_arm, cmd_imm, cmd_stop, cmd_done; // Write commands
  logic [3:0] seq_view, flag_view; // Advanced mode status

  // Window geometry clamped to the buffer size
  always_comb begin
    winl = (cfg_r.win_log2 > `LA_MAX_LOG2) ? `LA_MAX_LOG2 : cfg_r.win_log2;
    wlog = (cfg_r.depth_log2 > 4'(`LA_MAX_LOG2 - winl)) ?
           4'(`LA_MAX_LOG2 - winl) : cfg_r.depth_log2;
    wdepth = CW'(1) << wlog;
    nwin = CW'(1) << winl;
    last = CW'(wdepth - 1'b1);
    pos = {1'b0, tpos_r} & last;
    waddr = CW'((win_cnt << wlog) + samp_cnt);
  end

  // Sample and trigger qualifiers
  assign store_en = cfg_r.basic_capture ? I_CAPTURE_COND : 1'b1;
  assign trig = I_TRIGGER | imm_r;

  // Commands from a write data phase to the control register
  always_comb begin
    wr_dp = req_r.valid & req_r.write;
    cmd_arm = wr_dp && (req_r.addr == `LA_OFF_CTRL) && I_HWDATA[`LA_CTRL_ARM];
    cmd_imm = wr_dp && (req_r.addr == `LA_OFF_CTRL) && I_HWDATA[`LA_CTRL_IMM];
    cmd_stop = wr_dp && (req_r.addr == `LA_OFF_CTRL) && I_HWDATA[`LA_CTRL_STOP];
    cmd_done = wr_dp && (req_r.addr == `LA_OFF_CTRL) && I_HWDATA[`LA_CTRL_DONE];
  end

  // Run state sequence
  always_comb begin
    state_nxt = state_r;
    imm_nxt = imm_r;
    avail_nxt = avail_r;
    win_clr = 1'b0;
    win_inc = 1'b0;
    samp_clr = 1'b0;
    samp_inc = 1'b0;
    tot_clr = 1'b0;
    mem_we = 1'b0;
    mem_mark = 1'b0;
    win_done = 1'b0;
    case (state_r)
      ST_IDLE: begin
        // Counts held at zero while idle
        win_clr = 1'b1;
        samp_clr = 1'b1;
        tot_clr = 1'b1;
        if (cmd_arm || cmd_imm) begin
          imm_nxt = cmd_imm;
          avail_nxt = '0;
          state_nxt = (pos == '0) ? ST_WAIT : ST_PRE;
        end
      end
      ST_PRE: begin
        // Samples ahead of the trigger point
        if (store_en) begin
          mem_we = 1'b1;
          samp_inc = 1'b1;
          if (CW'(samp_cnt + 1'b1) == pos) begin
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // Trigger sample is stored with its mark
        if (trig) begin
          mem_we = 1'b1;
          mem_mark = 1'b1;
          samp_inc = 1'b1;
          if (pos == last) begin
            win_done = 1'b1;
          end else begin
            state_nxt = ST_POST;
          end
        end
      end
      ST_POST: begin
        // Samples after the trigger point
        if (store_en) begin
          mem_we = 1'b1;
          samp_inc = 1'b1;
          if (CW'(samp_cnt + 1'b1) == wdepth) begin
            win_done = 1'b1;
          end
        end
      end
      ST_FULL: begin
        // Held until the host reports upload complete
        if (cmd_done) begin
          state_nxt = ST_IDLE;
          imm_nxt = 1'b0;
          win_clr = 1'b1;
          samp_clr = 1'b1;
          tot_clr = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Window complete: next window or whole buffer full
    if (win_done) begin
      samp_clr = 1'b1;
      if (win_cnt == CW'(nwin - 1'b1)) begin
        state_nxt = ST_FULL;
        avail_nxt = nwin;
      end else begin
        win_inc = 1'b1;
        state_nxt = (pos == '0) ? ST_WAIT : ST_PRE;
      end
    end
    // Stop halts the run and offers what was filled
    if (cmd_stop && (state_r == ST_PRE || state_r == ST_WAIT || state_r == ST_POST)) begin
      mem_we = 1'b0;
      mem_mark = 1'b0;
      samp_inc = 1'b0;
      samp_clr = 1'b0;
      win_inc = 1'b0;
      state_nxt = ST_FULL;
      avail_nxt = CW'(win_cnt + {8'h00, state_r == ST_POST});
    end
  end

  // Engine registers
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r <= ST_IDLE;
      imm_r <= 1'b0;
      avail_r <= '0;
    end else begin
      state_r <= state_nxt;
      imm_r <= imm_nxt;
      avail_r <= avail_nxt;
    end
  end

  // Sample buffer, nothing written outside the capture states
  always_ff @(posedge I_CLK) begin
    if (mem_we) begin
      mem[waddr[7:0]] <= {mem_mark, I_PROBE};
    end
  end

  // Window index, sample count and total count
  cap_counter #(.W(CW)) u_win_cnt (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_clr(win_clr),
    .i_inc(win_inc),
    .o_count(win_cnt)
  );
  cap_counter #(.W(CW)) u_samp_cnt (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_clr(samp_clr),
    .i_inc(samp_inc),
    .o_count(samp_cnt)
  );
  cap_counter #(.W(CW)) u_tot_cnt (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_clr(tot_clr),
    .i_inc(mem_we),
    .o_count(tot_cnt)
  );

  // Advanced mode status views
  assign flag_view = cfg_r.advanced ? I_TSM_FLAGS : 4'h0;
  assign seq_view = (cfg_r.advanced && state_r == ST_WAIT) ? I_TSM_STATE : 4'h0;

  // Bus address phase capture, writes and read data
  always_comb begin
    req_nxt.valid = I_HSEL & I_HTRANS[1] & I_HREADY;
    req_nxt.write = I_HWRITE;
    req_nxt.addr = I_HADDR[`LA_ADDR_W-1:0];
    cfg_nxt = cfg_r;
    tpos_nxt = tpos_r;
    rdaddr_nxt = rdaddr_r;
    hrdata_nxt = 32'h0000_0000;
    // Write data phase
    if (wr_dp) begin
      case (req_r.addr)
        `LA_OFF_CFG: cfg_nxt = I_HWDATA[9:0];
        `LA_OFF_TPOS: tpos_nxt = I_HWDATA[7:0];
        `LA_OFF_RDADDR: rdaddr_nxt = I_HWDATA[7:0];
        default: ;
      endcase
    end
    // Read address phase, data registered for the data phase
    if (req_nxt.valid && !I_HWRITE) begin
      case (req_nxt.addr)
        `LA_OFF_CFG: hrdata_nxt = {22'h0, cfg_r};
        `LA_OFF_TPOS: hrdata_nxt = {24'h0, tpos_r};
        `LA_OFF_STAT: begin
          hrdata_nxt[`LA_STAT_STATE] = state_r;
          hrdata_nxt[`LA_STAT_IMM] = imm_r;
          hrdata_nxt[`LA_STAT_FLAGS] = flag_view;
          hrdata_nxt[`LA_STAT_SEQ] = seq_view;
        end
        `LA_OFF_WIN: hrdata_nxt = {23'h0, win_cnt};
        `LA_OFF_CNT: hrdata_nxt = {23'h0, samp_cnt};
        `LA_OFF_TOTAL: hrdata_nxt = {23'h0, tot_cnt};
        `LA_OFF_AVAIL: hrdata_nxt = {23'h0, avail_r};
        `LA_OFF_RDADDR: hrdata_nxt = {24'h0, rdaddr_r};
        `LA_OFF_RDDATA: hrdata_nxt = {23'h0, mem[rdaddr_r]};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      req_r <= '0;
      cfg_r <= `LA_CFG_RST;
      tpos_r <= `LA_TPOS_RST;
      rdaddr_r <= `LA_RDADDR_RST;
      hrdata_r <= 32'h0000_0000;
    end else begin
      req_r <= req_nxt;
      cfg_r <= cfg_nxt;
      tpos_r <= tpos_nxt;
      rdaddr_r <= rdaddr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Zero wait states, always OKAY
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_HRDATA = hrdata_r;
  assign O_RUN_STATE = state_r;

  // Arm with nonzero position enters pre-trigger
  property p_arm_pre;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_r == ST_IDLE && cmd_arm && pos != '0) |=> (state_r == ST_PRE);
  endproperty
  a_arm_pre: assert property (p_arm_pre) else $error("arm did not enter pre-trigger");

  // Arm with zero position waits for trigger
  property p_arm_wait;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_r == ST_IDLE && (cmd_arm || cmd_imm) && pos == '0) |=> (state_r == ST_WAIT);
  endproperty
  a_arm_wait: assert property (p_arm_wait) else $error("arm did not enter waiting");

  // Immediate arm stores a marked sample each waiting cycle
  property p_imm_trig;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_r == ST_WAIT && imm_r && !cmd_stop) |-> (mem_we && mem_mark);
  endproperty
  a_imm_trig: assert property (p_imm_trig) else $error("immediate arm did not trigger");

  // Trigger before last position enters post-trigger
  property p_trig_post;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_r == ST_WAIT && trig && !cmd_stop && pos != last) |=> (state_r == ST_POST);
  endproperty
  a_trig_post: assert property (p_trig_post) else $error("trigger did not enter post-trigger");

  // Stop during a run offers filled windows
  property p_stop_full;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (cmd_stop && (state_r == ST_PRE || state_r == ST_WAIT))
      |=> (state_r == ST_FULL && avail_r == $past(win_cnt));
  endproperty
  a_stop_full: assert property (p_stop_full) else $error("stop gave wrong window count");

  // Stop after trigger also offers the partial window
  property p_stop_partial;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (cmd_stop && state_r == ST_POST) |=> (avail_r == CW'($past(win_cnt) + 1'b1));
  endproperty
  a_stop_partial: assert property (p_stop_partial) else $error("partial window not offered");

  // Full holds until upload done
  property p_full_hold;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_r == ST_FULL && !cmd_done) |=> (state_r == ST_FULL);
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("left full without upload done");

  // Counts read zero while idle
  property p_idle_zero;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_r == ST_IDLE) |-> (win_cnt == '0 && samp_cnt == '0 && tot_cnt == '0);
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("status counts not zero in idle");

  // No sample stored while full
  property p_full_quiet;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_r == ST_FULL) |-> !mem_we;
  endproperty
  a_full_quiet: assert property (p_full_quiet) else $error("sample stored while full");

  // Always mode stores every post-trigger cycle
  property p_always_store;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_r == ST_POST && !cfg_r.basic_capture && !cmd_stop) |-> ##1 ($past(tot_cnt) != tot_cnt);
  endproperty
  a_always_store: assert property (p_always_store) else $error("always mode skipped a sample");

  // Zero position re-arms straight into waiting
  property p_rearm_wait;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (win_done && !cmd_stop && pos == '0 && win_cnt != CW'(nwin - 1'b1)) |=> (state_r == ST_WAIT);
  endproperty
  a_rearm_wait: assert property (p_rearm_wait) else $error("window re-arm not immediate");

  // Sequencer state hidden outside waiting
  property p_seq_view;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (state_r != ST_WAIT) |-> (seq_view == 4'h0);
  endproperty
  a_seq_view: assert property (p_seq_view) else $error("sequencer state shown outside wait");
endmodule // la_capture_ctrl
`default_nettype wire

// ---- logic/la_map.svh ----
// Register offsets, field positions, reset values and sizes of the capture controller
`ifndef LA_MAP_SVH
`define LA_MAP_SVH

// Sizes
`define LA_PROBE_W 8
`define LA_ADDR_W 8
`define LA_CNT_W 9
`define LA_MAX_LOG2 4'h8

// Register byte offsets
`define LA_OFF_CTRL 8'h00
`define LA_OFF_CFG 8'h04
`define LA_OFF_TPOS 8'h08
`define LA_OFF_STAT 8'h0c
`define LA_OFF_WIN 8'h10
`define LA_OFF_CNT 8'h14
`define LA_OFF_TOTAL 8'h18
`define LA_OFF_AVAIL 8'h1c
`define LA_OFF_RDADDR 8'h20
`define LA_OFF_RDDATA 8'h24

// Command bits of the control register
`define LA_CTRL_ARM 0
`define LA_CTRL_IMM 1
`define LA_CTRL_STOP 2
`define LA_CTRL_DONE 3

// Status register fields
`define LA_STAT_STATE 2:0
`define LA_STAT_IMM 3
`define LA_STAT_FLAGS 7:4
`define LA_STAT_SEQ 11:8

// Reset values
`define LA_CFG_RST 10'h008
`define LA_TPOS_RST 8'h00
`define LA_RDADDR_RST 8'h00

`endif

// ---- logic/la_pkg.sv ----
// Types shared by the capture controller files
`include "la_map.svh"
package la_pkg;
  // Run states of the capture engine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE  = 3'b001,
    ST_WAIT = 3'b010,
    ST_POST = 3'b011,
    ST_FULL = 3'b100
  } run_state_t;

  // Latched bus address phase
  typedef struct packed {
    logic [`LA_ADDR_W-1:0] addr;
    logic write;
    logic valid;
  } bus_req_t;

  // Capture configuration word
  typedef struct packed {
    logic advanced;
    logic basic_capture;
    logic [3:0] win_log2;
    logic [3:0] depth_log2;
  } cap_cfg_t;
endpackage

// ---- logic/cap_counter.sv ----
// Clearable up-counter used for the capture status counts
`timescale 1ns/1ps
`default_nettype none
module cap_counter #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_clr,
  input wire logic i_inc,
  // Count
  output logic [W-1:0] o_count
);
  logic [W-1:0] count_r; // Current count
  logic [W-1:0] count_nxt; // Next count

  // Clear has priority over increment
  always_comb begin
    count_nxt = count_r;
    if (i_clr) begin
      count_nxt = '0;
    end else if (i_inc) begin
      count_nxt = W'(count_r + 1'b1);
    end
  end

  // Count register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign o_count = count_r;
endmodule // cap_counter
`default_nettype wire

// ---- testbench/probe_src.sv ----
// Model of the probed user design that feeds the capture controller
`timescale 1ns/1ps
`default_nettype none
module probe_src (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Bench requests
  input wire logic i_fire,
  input wire logic i_cond,
  input wire logic [7:0] i_rnd,
  // Probe side of the controller
  output logic [7:0] o_probe,
  output logic o_trigger,
  output logic o_cond,
  output logic [3:0] o_flags,
  output logic [3:0] o_state
);
  // Free-running count, so stored samples show any gap
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_probe <= 8'h00;
      o_flags <= 4'h0;
      o_state <= 4'h0;
    end else begin
      o_probe <= o_probe + 8'h01;
      o_flags <= i_rnd[3:0];
      o_state <= i_rnd[7:4];
    end
  end
  // Trigger and capture condition come straight from the bench
  assign o_trigger = i_fire;
  assign o_cond = i_cond;
endmodule // probe_src
`default_nettype wire

// ---- testbench/la_capture_ctrl_tb.sv ----
// Self-checking bench of the capture controller
`timescale 1ns/1ps
`default_nettype none
`include "la_map.svh"
module la_capture_ctrl_tb;
  import la_pkg::*;
  // Clock, reset, bus master
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  run_state_t run_state;
  // Probe side
  logic fire = 1'b0;
  logic cond = 1'b0;
  logic [7:0] rnd = 8'h00;
  logic [7:0] probe;
  logic trig;
  logic capc;
  logic [3:0] flags;
  logic [3:0] tstate;
  // Bookkeeping and model state
  int fail_count = 0;
  int checked = 0;
  logic [31:0] seed = 32'd69;
  logic [31:0] rd;
  logic [7:0] q[$];
  logic mk[$];

  always #2.5 clk = ~clk;

  la_capture_ctrl DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
    .I_PROBE(probe), .I_TRIGGER(trig), .I_CAPTURE_COND(capc), .I_TSM_FLAGS(flags),
    .I_TSM_STATE(tstate), .O_RUN_STATE(run_state));

  probe_src u_src (.i_clk(clk), .i_rst_n(rst_n), .i_fire(fire), .i_cond(cond), .i_rnd(rnd),
    .o_probe(probe), .o_trigger(trig), .o_cond(capc), .o_flags(flags), .o_state(tstate));

  // Next pseudo-random byte
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single AHB transfer, read data left in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    // Address phase held until ready, only the watchdog ends a hang
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Wait for a run state under a bound
  task automatic wst(input run_state_t s);
    int n;
    n = 0;
    while (run_state !== s && n < 3000) begin @(posedge clk); n++; end
    check("run state", {29'h0, run_state}, {29'h0, s});
  endtask

  // Upload n samples into the model queues
  task automatic dump(input int n);
    q.delete();
    mk.delete();
    for (int i = 0; i < n; i++) begin
      bus(1'b1, `LA_OFF_RDADDR, i);
      bus(1'b0, `LA_OFF_RDDATA, 32'h0);
      q.push_back(rd[7:0]);
      mk.push_back(rd[8]);
    end
  endtask

  // Run of consecutive samples, mark expected at index m of the run
  task automatic seg(input int from, input int n, input int m);
    for (int s = 0; s < n; s++) begin
      check("probe", {24'h0, q[from+s]}, {24'h0, 8'(q[from] + s)});
      check("mark", {31'h0, mk[from+s]}, {31'h0, s == m});
    end
  endtask

  // Upload finished, back to idle with cleared counts
  task automatic done_idle();
    bus(1'b1, `LA_OFF_CTRL, 32'h8);
    wst(ST_IDLE);
    bus(1'b0, `LA_OFF_WIN, 32'h0);
    check("window", rd, 32'h0);
    bus(1'b0, `LA_OFF_CNT, 32'h0);
    check("count", rd, 32'h0);
    bus(1'b0, `LA_OFF_TOTAL, 32'h0);
    check("total", rd, 32'h0);
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    int dl[3];
    int p;
    dl = '{0, 2, 8};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    check("run state", {29'h0, run_state}, 32'h0);
    check("resp", {31'h0, hresp}, 32'h0);
    check("ready", {31'h0, hreadyout}, 32'h1);
    bus(1'b0, `LA_OFF_CFG, 32'h0);
    check("cfg", rd, {22'h0, `LA_CFG_RST});
    bus(1'b0, 8'h30, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b1, `LA_OFF_RDADDR, 32'ha5);
    bus(1'b0, `LA_OFF_RDADDR, 32'h0);
    check("rdaddr", rd, 32'ha5);
    // Immediate arm over depths 1, 4 and 256
    foreach (dl[i]) begin
      bus(1'b1, `LA_OFF_CFG, dl[i]);
      bus(1'b1, `LA_OFF_TPOS, 32'h0);
      bus(1'b1, `LA_OFF_CTRL, 32'h2);
      wst(ST_FULL);
      fire <= 1'b1;
      repeat (10) @(posedge clk);
      fire <= 1'b0;
      bus(1'b0, `LA_OFF_TOTAL, 32'h0);
      check("total", rd, 32'h1 << dl[i]);
      check("run state", {29'h0, run_state}, {29'h0, ST_FULL});
      dump(1 << dl[i]);
      seg(0, 1 << dl[i], 0);
    done_idle();
    end
    // Normal arm with pre-trigger portion, middle and last position
    foreach (dl[i]) begin
      if (i == 2) break;
      p = (i == 0) ? 1 : 3;
      bus(1'b1, `LA_OFF_CFG, 32'h2);
      bus(1'b1, `LA_OFF_TPOS, p);
      bus(1'b1, `LA_OFF_CTRL, 32'h1);
      wst(ST_WAIT);
      repeat (20) @(posedge clk);
      check("run state", {29'h0, run_state}, {29'h0, ST_WAIT});
      bus(1'b0, `LA_OFF_CNT, 32'h0);
      check("count", rd, p);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      @(posedge clk);
      check("run state", {29'h0, run_state}, (p == 3) ? 32'h4 : 32'h3);
      wst(ST_FULL);
      dump(4);
      seg(0, p, -1);
      seg(p, 4 - p, 0);
      done_idle();
    end
    // Two windows, trigger held: back-to-back windows
    bus(1'b1, `LA_OFF_CFG, 32'h12);
    bus(1'b1, `LA_OFF_TPOS, 32'h0);
    fire <= 1'b1;
    bus(1'b1, `LA_OFF_CTRL, 32'h1);
    wst(ST_FULL);
    fire <= 1'b0;
    bus(1'b0, `LA_OFF_AVAIL, 32'h0);
    check("avail", rd, 32'h2);
    dump(8);
    seg(0, 4, 0);
    seg(4, 4, 0);
    check("gap", {24'h0, q[4]}, {24'h0, 8'(q[3] + 8'h01)});
    check("mark", {31'h0, mk[4]}, 32'h1);
    done_idle();
    // Stop after one filled window, second one waiting
    bus(1'b1, `LA_OFF_CTRL, 32'h1);
    wst(ST_WAIT);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, `LA_OFF_WIN, 32'h0);
    check("window", rd, 32'h1);
    bus(1'b1, `LA_OFF_CTRL, 32'h4);
    bus(1'b0, `LA_OFF_AVAIL, 32'h0);
    check("avail", rd, 32'h1);
    done_idle();
    // Basic capture: stall in post, one conditional sample, partial stop
    bus(1'b1, `LA_OFF_CFG, 32'h102);
    bus(1'b1, `LA_OFF_CTRL, 32'h2);
    wst(ST_POST);
    repeat (10) @(posedge clk);
    bus(1'b0, `LA_OFF_TOTAL, 32'h0);
    check("total", rd, 32'h1);
    cond <= 1'b1;
    @(posedge clk);
    cond <= 1'b0;
    repeat (3) @(posedge clk);
    bus(1'b0, `LA_OFF_TOTAL, 32'h0);
    check("total", rd, 32'h2);
    bus(1'b1, `LA_OFF_CTRL, 32'h4);
    bus(1'b0, `LA_OFF_AVAIL, 32'h0);
    check("avail", rd, 32'h1);
    done_idle();
    // Sequencer flags and state, basic then advanced
    rnd <= xs();
    bus(1'b0, `LA_OFF_STAT, 32'h0);
    check("status", rd, 32'h0);
    bus(1'b1, `LA_OFF_CFG, 32'h202);
    bus(1'b0, `LA_OFF_STAT, 32'h0);
    check("status", rd, {24'h0, rnd[3:0], 4'h0});
    bus(1'b1, `LA_OFF_CTRL, 32'h1);
    wst(ST_WAIT);
    repeat (3) begin
      rnd <= xs();
      repeat (2) @(posedge clk);
      bus(1'b0, `LA_OFF_STAT, 32'h0);
      check("status", rd, {20'h0, rnd, 4'h2});
    end
    bus(1'b1, `LA_OFF_CTRL, 32'h4);
    done_idle();
    end_of_test();
  end
endmodule // la_capture_ctrl_tb
`default_nettype wire
